// *** ebc_apb_regs.sv ***
`timescale 1ns/100ps
module ebc_apb_regs
  import ebc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Block side
  output logic [3:0] ctrl_out,
  output logic [22:0] phase_out,
  output logic [25:0] cmd_out,
  output logic [15:0] wdata_out,
  output logic start_out,
  input wire logic busy_in,
  input wire logic rdy_waited_in,
  input wire logic [15:0] rdata_in
);

  logic access_wr;
  logic known;

  assign access_wr = psel_in && penable_in && pwrite_in && pready_out;
  assign known = (paddr_in == EBC_OFF_CTRL) || (paddr_in == EBC_OFF_PHASE) ||
    (paddr_in == EBC_OFF_CMD) || (paddr_in == EBC_OFF_WDATA) ||
    (paddr_in == EBC_OFF_STATUS) || (paddr_in == EBC_OFF_RDATA);

  // No wait cycle: answer in the access phase's first edge
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pready_out <= 1'b0;
      pslverr_out <= 1'b0;
      prdata_out <= 32'h00000000;
    end
    else
    begin
      pready_out <= psel_in && !penable_in;
      pslverr_out <= psel_in && !penable_in && !known;
      prdata_out <= 32'h00000000;
      if (psel_in && !penable_in && !pwrite_in)
      begin
        case (paddr_in)
          EBC_OFF_CTRL: prdata_out <= {28'h0000000, ctrl_out};
          EBC_OFF_PHASE: prdata_out <= {9'h000, phase_out};
          EBC_OFF_CMD: prdata_out <= {6'h00, cmd_out};
          EBC_OFF_WDATA: prdata_out <= {16'h0000, wdata_out};
          EBC_OFF_STATUS: prdata_out <= {30'h00000000, rdy_waited_in, busy_in};
          EBC_OFF_RDATA: prdata_out <= {16'h0000, rdata_in};
          default: prdata_out <= 32'h00000000;
        endcase
      end
    end
  end

  // Writes land only at the edge that completes the transfer
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_out <= EBC_CTRL_RESET;
      phase_out <= EBC_PHASE_RESET;
      cmd_out <= 26'h0000000;
      wdata_out <= 16'h0000;
      start_out <= 1'b0;
    end
    else
    begin
      start_out <= 1'b0;
      if (access_wr)
      begin
        case (paddr_in)
          EBC_OFF_CTRL: ctrl_out <= pwdata_in[3:0];
          EBC_OFF_PHASE: phase_out <= pwdata_in[22:0];
          EBC_OFF_WDATA: wdata_out <= pwdata_in[15:0];
          EBC_OFF_CMD:
          begin
            // A command while busy is dropped
            if (!busy_in)
            begin
              cmd_out <= pwdata_in[25:0];
              start_out <= 1'b1;
            end
          end
          default: ctrl_out <= ctrl_out;
        endcase
      end
    end
  end

endmodule

// *** ebc_bus_model.sv ***
`timescale 1ns/100ps
module ebc_bus_model (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Bus from controller
  input wire logic cs_n_in,
  input wire logic rd_n_in,
  input wire logic wr_n_in,
  input wire logic ale_in,
  input wire logic [23:0] addr_in,
  input wire logic [15:0] data_in,
  input wire logic [15:0] shared_in,
  // Device setup
  input wire logic mux_in,
  input wire logic pol_in,
  input wire logic [3:0] wait_in,
  // Answers
  output logic [15:0] data_out,
  output logic [15:0] shared_out,
  output logic ready_out,
  output logic [23:0] last_addr_out,
  output logic [15:0] last_wdata_out
);
  logic [15:0] lat;
  logic [15:0] hold;
  logic [15:0] rv;
  logic [4:0] cnt;
  logic cmd;
  assign cmd = !cs_n_in && (!rd_n_in || !wr_n_in);
  assign rv = (mux_in ? lat : addr_in[15:0]) ^ 16'hA5C3;
  // Released lines toggle so a late sample never sees valid data
  assign data_out = (!mux_in && !rd_n_in) ? rv : ~hold;
  assign shared_out = (mux_in && !rd_n_in) ? rv : ~hold;
  always_ff @(posedge clk_in or posedge rst_in)
    if (rst_in)
    begin
      lat <= 16'h0000;
      hold <= 16'h0000;
      cnt <= 5'h00;
      ready_out <= 1'b0;
      last_addr_out <= 24'h000000;
      last_wdata_out <= 16'h0000;
    end
    else
    begin
      hold <= ~hold;
      if (ale_in)
        lat <= shared_in;
      cnt <= cmd ? cnt + 5'h01 : 5'h00;
      // Held until the strobe ends, then dropped before the next cycle
      ready_out <= (cmd && cnt >= 5'(wait_in)) ? pol_in : !pol_in;
      if (cmd)
        last_addr_out <= mux_in ? {8'h00, lat} : addr_in;
      if (cmd && !wr_n_in)
        last_wdata_out <= mux_in ? shared_in : data_in;
    end
endmodule

// *** ebc_ctrl.sv ***
`timescale 1ns/100ps
// Operation
// - Each access walks address, second, third, access, final hold phases in order.
// - Phase lengths programmable; clamped to AB 1..5, C 0..3, D 0..1, E 1..32, F 0..3.
// - Ready may stretch access phase, honoured only when ready control is enabled.
// - Ready active level selectable, high or low.
// - Synchronous ready, driven on reference clock, gives shortest cycle.
// - Asynchronous ready passes extra sync stage, costing at least one wait.
// - First sample point follows programmed phases and differs sync versus async.
// - Ready inactive at sample point inserts one wait and samples again.
// - Ready active at sample point ends the bus cycle.
// - Read data captured on the edge that ends read strobe and address.
// - Pin transitions at least 12.5 ns apart; met here by slow clock.
// - Reference clock output equals system clock, one period per cycle.
// - Multiplexed mode drives address then write data on shared lines.
// - Demultiplexed mode drives address and data on separate lines.
module ebc_ctrl
  import ebc_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
)
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // APB
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Bus reference clock
  output logic bus_reference_clock_out,
  // Strobes
  output logic cs_n_out,
  output logic rd_n_out,
  output logic wr_n_out,
  output logic ale_out,
  output logic upper_byte_enable_n_out,
  input wire logic ready_in,
  // Separate lines
  output logic [ADDR_W-1:0] address_lines_out,
  output logic [DATA_W-1:0] data_lines_out,
  output logic data_lines_oe_out,
  input wire logic [DATA_W-1:0] data_lines_in,
  // Shared lines
  output logic [DATA_W-1:0] shared_addr_data_lines_out,
  output logic shared_addr_data_lines_oe_out,
  input wire logic [DATA_W-1:0] shared_addr_data_lines_in
);

  logic [3:0] ctrl;
  logic [22:0] phase;
  logic [25:0] cmd;
  logic [15:0] wdata;
  logic start;
  logic [15:0] rdata;
  logic busy;
  logic rdy_waited;
  logic [31:0] prdata_i;
  logic pready_i;
  logic pslverr_i;
  logic ready_s2;
  logic ready_s3;
  logic [DATA_W-1:0] din_s1;
  logic [DATA_W-1:0] din_s2;
  logic [DATA_W-1:0] ain_s1;
  logic [DATA_W-1:0] ain_s2;
  ebc_state_type state;
  ebc_state_type next_state;
  logic [5:0] cnt;
  logic [5:0] next_cnt;
  logic [2:0] len_ab;
  logic [1:0] len_c;
  logic [0:0] len_d;
  logic [5:0] len_e;
  logic [1:0] len_f;
  logic mux;
  logic is_wr;
  logic rdy_en;
  logic rdy_async;
  logic rdy_pol;
  logic rdy_active;
  logic sample_pt;
  logic [5:0] sample_cnt;
  logic done_e;
  logic [1:0] cap_dly;

  ebc_apb_regs u_regs (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .psel_in(psel_in),
    .penable_in(penable_in),
    .pwrite_in(pwrite_in),
    .paddr_in(paddr_in),
    .pwdata_in(pwdata_in),
    .prdata_out(prdata_i),
    .pready_out(pready_i),
    .pslverr_out(pslverr_i),
    .ctrl_out(ctrl),
    .phase_out(phase),
    .cmd_out(cmd),
    .wdata_out(wdata),
    .start_out(start),
    .busy_in(busy),
    .rdy_waited_in(rdy_waited),
    .rdata_in(rdata)
  );

  assign prdata_out = prdata_i;
  assign pready_out = pready_i;
  assign pslverr_out = pslverr_i;

  // Ready and read data come from off chip: two flops before use
  ebc_sync u_rdy_sync (
    .clk_sys_in(clk_sys_in),
    .rst_in(rst_in),
    .async_in(ready_in),
    .sync_out(ready_s2)
  );

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      din_s1 <= '0;
      din_s2 <= '0;
      ain_s1 <= '0;
      ain_s2 <= '0;
      ready_s3 <= 1'b0;
    end
    else
    begin
      din_s1 <= data_lines_in;
      din_s2 <= din_s1;
      ain_s1 <= shared_addr_data_lines_in;
      ain_s2 <= ain_s1;
      ready_s3 <= ready_s2;
    end
  end

  // Clamp programmed lengths to legal ranges
  always_comb
  begin
    len_ab = phase[EBC_PH_AB_LSB +: 3];
    if (len_ab < EBC_AB_MIN)
      len_ab = EBC_AB_MIN;
    if (len_ab > EBC_AB_MAX)
      len_ab = EBC_AB_MAX;
    len_c = phase[EBC_PH_C_LSB +: 2];
    len_d = phase[EBC_PH_D_LSB +: 1];
    len_e = phase[EBC_PH_E_LSB +: 6];
    if (len_e < EBC_E_MIN)
      len_e = EBC_E_MIN;
    if (len_e > EBC_E_MAX)
      len_e = EBC_E_MAX;
    len_f = phase[EBC_PH_F_LSB +: 2];
  end

  assign mux = ctrl[EBC_CTRL_MUX_BIT];
  assign rdy_en = ctrl[EBC_CTRL_RDY_EN_BIT];
  assign rdy_pol = ctrl[EBC_CTRL_RDY_POL_BIT];
  assign rdy_async = ctrl[EBC_CTRL_RDY_ASYNC_BIT];
  assign is_wr = cmd[EBC_CMD_WRITE_BIT];
  // Async path adds one flop, hence one extra wait at least
  assign rdy_active = (rdy_async ? ready_s3 : ready_s2) == rdy_pol;
  // First sample at the last programmed access cycle; async one cycle later
  assign sample_cnt = rdy_async ? 6'h00 : 6'h01;
  assign sample_pt = (state == EBC_E) && (cnt <= sample_cnt) && rdy_en;
  assign done_e = rdy_en ? (sample_pt && rdy_active) : (cnt == 6'h01);
  // Busy until the captured read word has reached its register
  assign busy = (state != EBC_IDLE) || (cap_dly != 2'b00);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      EBC_IDLE:
      begin
        if (start)
        begin
          next_state = EBC_AB;
          next_cnt = {3'h0, len_ab};
        end
      end
      EBC_AB:
      begin
        if (cnt == 6'h01)
        begin
          next_state = EBC_C;
          next_cnt = {4'h0, len_c};
          if (len_c == 2'h0)
          begin
            next_state = EBC_D;
            next_cnt = {5'h00, len_d};
            if (len_d == 1'h0)
            begin
              next_state = EBC_E;
              next_cnt = len_e;
            end
          end
        end
        else
          next_cnt = cnt - 6'h01;
      end
      EBC_C:
      begin
        if (cnt <= 6'h01)
        begin
          next_state = EBC_D;
          next_cnt = {5'h00, len_d};
          if (len_d == 1'h0)
          begin
            next_state = EBC_E;
            next_cnt = len_e;
          end
        end
        else
          next_cnt = cnt - 6'h01;
      end
      EBC_D:
      begin
        next_state = EBC_E;
        next_cnt = len_e;
      end
      EBC_E:
      begin
        if (done_e)
        begin
          next_state = (len_f == 2'h0) ? EBC_IDLE : EBC_F;
          next_cnt = {4'h0, len_f};
        end
        else if (cnt > 6'h00)
          next_cnt = cnt - 6'h01;
      end
      EBC_F:
      begin
        if (cnt <= 6'h01)
          next_state = EBC_IDLE;
        else
          next_cnt = cnt - 6'h01;
      end
      default:
      begin
        next_state = EBC_IDLE;
        next_cnt = 6'h00;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      state <= EBC_IDLE;
      cnt <= 6'h00;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Ready wait flag for status
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      rdy_waited <= 1'b0;
    else if (start)
      rdy_waited <= 1'b0;
    else if (sample_pt && !rdy_active)
      rdy_waited <= 1'b1;
  end

  // Pins are sampled at the edge that leaves the access phase,
  // then ride both sync flops before the word is kept
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      cap_dly <= 2'b00;
    else
      cap_dly <= {cap_dly[0], (state == EBC_E) && done_e && !is_wr};
  end

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
      rdata <= 16'h0000;
    else if (cap_dly[1])
      rdata <= mux ? ain_s2 : din_s2;
  end

  // Clock forwarded as is; a flop could only halve its rate
  assign bus_reference_clock_out = clk_sys_in;

  // Pins: each changes at most once per 40 ns clock, above 12.5 ns spacing
  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      cs_n_out <= 1'b1;
      rd_n_out <= 1'b1;
      wr_n_out <= 1'b1;
      ale_out <= 1'b0;
      upper_byte_enable_n_out <= 1'b1;
      address_lines_out <= '0;
      data_lines_out <= '0;
      data_lines_oe_out <= 1'b0;
      shared_addr_data_lines_out <= '0;
      shared_addr_data_lines_oe_out <= 1'b0;
    end
    else
    begin
      cs_n_out <= (next_state == EBC_IDLE);
      ale_out <= mux && (next_state == EBC_AB);
      rd_n_out <= !((next_state == EBC_E) && !is_wr);
      wr_n_out <= !((next_state == EBC_E) && is_wr);
      if (next_state == EBC_AB && state == EBC_IDLE)
      begin
        address_lines_out <= cmd[ADDR_W-1:0];
        upper_byte_enable_n_out <= !cmd[EBC_CMD_BHE_BIT];
      end
      else if (next_state == EBC_IDLE)
        upper_byte_enable_n_out <= 1'b1;
      if (mux)
      begin
        data_lines_oe_out <= 1'b0;
        if (next_state == EBC_AB)
        begin
          shared_addr_data_lines_out <= cmd[DATA_W-1:0];
          shared_addr_data_lines_oe_out <= 1'b1;
        end
        else if (is_wr && (next_state != EBC_IDLE))
        begin
          shared_addr_data_lines_out <= wdata;
          shared_addr_data_lines_oe_out <= 1'b1;
        end
        else
          shared_addr_data_lines_oe_out <= 1'b0;
      end
      else
      begin
        shared_addr_data_lines_oe_out <= 1'b0;
        data_lines_out <= wdata;
        data_lines_oe_out <= is_wr && (next_state != EBC_IDLE);
      end
    end
  end

  sequence s_leave_e;
    (state == EBC_E) && done_e;
  endsequence

  a_phase_order_ab: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == EBC_AB) |=> (state inside {EBC_AB, EBC_C, EBC_D, EBC_E}))
    else $error("address phase left to wrong phase");
  a_phase_order_f: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == EBC_F) |=> (state inside {EBC_F, EBC_IDLE}))
    else $error("final phase left to wrong phase");
  a_access_min_len: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(state == EBC_E) && !rdy_en && (len_e == 6'h02) |=> (state == EBC_E) ##1
    (state != EBC_E))
    else $error("access phase length wrong");
  a_ready_ignored: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    (state == EBC_E) && !rdy_en && (cnt > 6'h01) |=> (state == EBC_E))
    else $error("access phase ended early without ready control");
  a_ready_wait: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    sample_pt && !rdy_active |=> (state == EBC_E))
    else $error("inactive ready did not insert wait");
  a_ready_end: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    sample_pt && rdy_active |=> (state != EBC_E))
    else $error("active ready did not end cycle");
  a_read_capture: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    s_leave_e ##0 !is_wr |=> rd_n_out ##2 (rdata == $past(mux ? ain_s1 : din_s1, 2)))
    else $error("read data not taken at strobe end");
  a_ale_mux: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    ale_out |-> mux && (state == EBC_AB))
    else $error("address latch strobe outside address phase");
  a_demux_lines: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    !mux |-> !shared_addr_data_lines_oe_out)
    else $error("shared lines driven in separate mode");

endmodule

// *** ebc_ctrl_tb_top.sv ***
`timescale 1ns/100ps
module ebc_ctrl_tb_top;
  import ebc_pkg::*;
  logic clk_sys_in, rst_in, psel, penable, pwrite, pready, pslverr, refclk;
  logic cs_n, rd_n, wr_n, ale, ready, doe, soe, mux, pol, err, cs_prev, ube_n, ube_seen, ub;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, ph;
  logic [31:0] st = 32'h00000041;
  logic [23:0] addr, m_addr, a;
  logic [15:0] dout, din, sout, sin, m_dat, m_sh, m_wdata, wd;
  logic [3:0] wt;
  int bad_count, total_checks, cs_len, ale_cnt, ab, c, d, e, f, w, lens[8];
  assign din = doe ? dout : m_dat;
  assign sin = soe ? sout : m_sh;
  ebc_ctrl u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .psel_in(psel),
    .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata),
    .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
    .bus_reference_clock_out(refclk), .cs_n_out(cs_n), .rd_n_out(rd_n), .wr_n_out(wr_n),
    .ale_out(ale), .upper_byte_enable_n_out(ube_n), .ready_in(ready), .address_lines_out(addr),
    .data_lines_out(dout), .data_lines_oe_out(doe), .data_lines_in(din),
    .shared_addr_data_lines_out(sout), .shared_addr_data_lines_oe_out(soe),
    .shared_addr_data_lines_in(sin));
  ebc_bus_model u_mem (.clk_in(clk_sys_in), .rst_in(rst_in), .cs_n_in(cs_n), .rd_n_in(rd_n),
    .wr_n_in(wr_n), .ale_in(ale), .addr_in(addr), .data_in(dout), .shared_in(sin),
    .mux_in(mux), .pol_in(pol), .wait_in(wt), .data_out(m_dat), .shared_out(m_sh),
    .ready_out(ready), .last_addr_out(m_addr), .last_wdata_out(m_wdata));
  initial
  begin
    clk_sys_in = 1'b0;
    forever #20 clk_sys_in = ~clk_sys_in;
  end
  // Length of each chip-select window and address strobes within it
  always @(posedge clk_sys_in)
  begin
    cs_prev <= cs_n;
    if (!cs_n)
      cs_len <= cs_prev ? 1 : cs_len + 1;
    if (!cs_n)
      ube_seen <= ube_n;
    if (cs_prev && !cs_n)
      ale_cnt <= int'(ale);
    else if (ale)
      ale_cnt <= ale_cnt + 1;
  end
  function automatic logic [31:0] xs();
    st = st ^ (st << 13);
    st = st ^ (st >> 17);
    st = st ^ (st << 5);
    return st;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] dt);
    int n;
    @(posedge clk_sys_in);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= dt;
    @(posedge clk_sys_in);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk_sys_in);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      bad_count++;
      conclude();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic run(input logic [31:0] ctrl, input logic [31:0] cmd);
    int n;
    apb(1'b1, EBC_OFF_CTRL, ctrl);
    apb(1'b1, EBC_OFF_PHASE, ph);
    apb(1'b1, EBC_OFF_WDATA, {16'h0000, wd});
    apb(1'b1, EBC_OFF_CMD, cmd);
    n = 0;
    do
    begin
      apb(1'b0, EBC_OFF_STATUS, 32'h0);
      n++;
    end
    while (rd[0] !== 1'b0 && n < 100);
    if (n >= 100)
    begin
      bad_count++;
      conclude();
    end
  endtask
  function automatic logic [31:0] pack();
    return (32'(ab) << EBC_PH_AB_LSB) | (32'(c) << EBC_PH_C_LSB) | (32'(d) << EBC_PH_D_LSB)
      | (32'(e) << EBC_PH_E_LSB) | (32'(f) << EBC_PH_F_LSB);
  endfunction
  initial
  begin
    repeat (100000) @(posedge clk_sys_in);
    bad_count++;
    conclude();
  end
  initial
  begin
    {psel, penable, pwrite, paddr, pwdata, mux, pol, wt} = '0;
    rst_in = 1'b1;
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    apb(1'b0, EBC_OFF_CTRL, 32'h0);
    chk(rd, 32'(EBC_CTRL_RESET));
    apb(1'b0, EBC_OFF_PHASE, 32'h0);
    chk(rd, 32'(EBC_PHASE_RESET));
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    @(posedge clk_sys_in);
    #5;
    chk({31'h0, refclk}, 32'h1);
    @(negedge clk_sys_in);
    #5;
    chk({31'h0, refclk}, 32'h0);
    $display("test registers done");
    // Ready held back but disabled: cycles keep their programmed length
    for (int i = 0; i < 12; i++)
    begin
      ab = 1 + int'(xs() % 2);
      c = int'(xs() % 4);
      d = int'(xs() % 2);
      f = int'(xs() % 4);
      w = (i / 2) % 2;
      e = 1 + int'(xs() % 6);
      a = xs() & 24'hFFFFFF;
      wd = xs() & 16'hFFFF;
      ph = pack();
      mux <= i[0];
      pol <= 1'b1;
      wt <= 4'h5;
      ub = 1'(xs());
      run({31'h0, i[0]}, {6'h00, ub, w[0], a});
      chk(32'(cs_len), 32'(ab + c + d + e + f));
      chk(32'(ale_cnt > 0), {31'h0, i[0]});
      chk({31'h0, ube_seen}, {31'h0, ~ub});
      if (w == 1)
      begin
        chk({16'h0, m_wdata}, {16'h0, wd});
        chk({8'h0, m_addr}, i[0] ? {16'h0, a[15:0]} : {8'h0, a});
      end
      else
      begin
        apb(1'b0, EBC_OFF_RDATA, 32'h0);
        chk(rd, {16'h0, a[15:0] ^ 16'hA5C3});
      end
    end
    $display("test transfers done");
    {ab, c, d, e, f} = {1, 1, 0, 2, 1};
    ph = pack();
    for (int i = 0; i < 8; i++)
    begin
      w = i[2] ? 3 : 0;
      pol <= i[0];
      wt <= 4'(w);
      mux <= 1'b0;
      wd = xs() & 16'hFFFF;
      run({28'h0, i[1], i[0], 2'b10}, {8'h01, 24'(xs())});
      chk(32'(cs_len >= 5 + w && cs_len <= 10 + w), 32'h1);
      if (!i[1])
        lens[i] = cs_len;
      else
        chk(32'(cs_len > lens[i - 2]), 32'h1);
      if (w == 3)
      begin
        apb(1'b0, EBC_OFF_STATUS, 32'h0);
        chk({31'h0, rd[1]}, 32'h1);
      end
    end
    $display("test ready done");
    conclude();
  end
endmodule

// *** ebc_pkg.sv ***
package ebc_pkg;

  // APB register byte offsets
  localparam logic [7:0] EBC_OFF_CTRL = 8'h00;
  localparam logic [7:0] EBC_OFF_PHASE = 8'h04;
  localparam logic [7:0] EBC_OFF_CMD = 8'h08;
  localparam logic [7:0] EBC_OFF_WDATA = 8'h0C;
  localparam logic [7:0] EBC_OFF_STATUS = 8'h10;
  localparam logic [7:0] EBC_OFF_RDATA = 8'h14;

  // Control register fields
  localparam int EBC_CTRL_MUX_BIT = 0;
  localparam int EBC_CTRL_RDY_EN_BIT = 1;
  localparam int EBC_CTRL_RDY_POL_BIT = 2;
  localparam int EBC_CTRL_RDY_ASYNC_BIT = 3;
  localparam logic [3:0] EBC_CTRL_RESET = 4'h0;

  // Phase register fields, each phase length in bus clock units
  localparam int EBC_PH_AB_LSB = 0;
  localparam int EBC_PH_C_LSB = 4;
  localparam int EBC_PH_D_LSB = 8;
  localparam int EBC_PH_E_LSB = 12;
  localparam int EBC_PH_F_LSB = 20;
  localparam logic [22:0] EBC_PHASE_RESET = 23'h001001;

  // Phase length limits
  localparam logic [2:0] EBC_AB_MIN = 3'h1;
  localparam logic [2:0] EBC_AB_MAX = 3'h5;
  localparam logic [1:0] EBC_C_MAX = 2'h3;
  localparam logic [0:0] EBC_D_MAX = 1'h1;
  localparam logic [5:0] EBC_E_MIN = 6'h01;
  localparam logic [5:0] EBC_E_MAX = 6'h20;
  localparam logic [1:0] EBC_F_MAX = 2'h3;

  // Command register fields
  localparam int EBC_CMD_WRITE_BIT = 24;
  localparam int EBC_CMD_BHE_BIT = 25;

  // Pin transition spacing against the system clock
  localparam real EBC_MIN_TRANS_NS = 12.5;
  localparam real EBC_CLK_NS = 40.0;
  localparam int EBC_MIN_TRANS_CYC =
    (int'($ceil(EBC_MIN_TRANS_NS / EBC_CLK_NS)) < 1) ? 1 :
    int'($ceil(EBC_MIN_TRANS_NS / EBC_CLK_NS));

  typedef enum logic [5:0] {
    EBC_IDLE = 6'b000001,
    EBC_AB = 6'b000010,
    EBC_C = 6'b000100,
    EBC_D = 6'b001000,
    EBC_E = 6'b010000,
    EBC_F = 6'b100000
  } ebc_state_type;

endpackage

// *** ebc_sync.sv ***
`timescale 1ns/100ps
module ebc_sync
  import ebc_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Level
  input wire logic async_in,
  output logic sync_out
);

  logic stage_one;

  always_ff @(posedge clk_sys_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      stage_one <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      stage_one <= async_in;
      sync_out <= stage_one;
    end
  end

endmodule
